/* File: logic/cbr_pkg.sv */
// Constants for the upper configuration register bank of the clock buffer
package cbr_pkg;
   // Register indices
   localparam logic [7:0] CBR_IDX_SLEW     = 8'h03;
   localparam logic [7:0] CBR_IDX_RSVD     = 8'h04;
   localparam logic [7:0] CBR_IDX_REVMAKER = 8'h05;
   localparam logic [7:0] CBR_IDX_CATIDENT = 8'h06;
   localparam logic [7:0] CBR_IDX_LENGTH   = 8'h07;
   // Field positions
   localparam int CBR_SLEW_BIT    = 0;
   localparam int CBR_LEN_MSB     = 4;
   localparam int CBR_LEN_WIDTH   = 5;
   // Reset and fixed readback values
   localparam logic       CBR_SLEW_RESET  = 1'b1;
   localparam logic [4:0] CBR_LEN_RESET   = 5'h08;
   localparam logic [6:0] CBR_SLEW_RSVD   = 7'h62;
   localparam logic [7:0] CBR_RSVD_VALUE  = 8'hFF;
   localparam logic [7:0] CBR_UNHELD      = 8'h00;
   // Block read sequencer states, Gray from CBR_IDLE through CBR_COUNT to CBR_DATA
   typedef enum logic [1:0] {
      CBR_IDLE  = 2'b00,
      CBR_COUNT = 2'b01,
      CBR_DATA  = 2'b11
   } cbr_state_t;
endpackage

/* File: logic/cbr_regs.sv */
// Upper register bank (bytes 3 to 7) with byte write and block read sequencer
`timescale 1ns/1ps
module cbr_regs #(
   parameter logic [3:0] REVISION_CODE = 4'h3, // Arbitrary value
   parameter logic [3:0] MAKER_CODE    = 4'h5, // Arbitrary value
   parameter logic [1:0] CATEGORY_CODE = 2'h2, // Arbitrary value
   parameter logic [5:0] PART_IDENT    = 6'h15 // Arbitrary value
) (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic       wr_en_i,
   input  wire logic [7:0] wr_index_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic       rd_start_i,
   input  wire logic [7:0] rd_begin_i,
   input  wire logic       rd_next_i,
   input  wire logic       rd_abort_i,
   output logic [7:0]      rd_data_o,
   output logic            rd_valid_o,
   output logic            rd_last_o,
   output logic            edge_speed_select_out8_o,
   output logic [4:0]      read_length_o
);
   import cbr_pkg::*;

   logic             slew;
   logic             next_slew;
   logic [4:0]       length;
   logic [4:0]       next_length;
   cbr_state_t       state;
   cbr_state_t       next_state;
   logic [7:0]       index;
   logic [7:0]       next_index;
   logic [4:0]       remain;
   logic [4:0]       next_remain;
   logic [7:0]       data;
   logic [7:0]       next_data;

   ////////////////////////////////////////////////////////////////////////////
   // Readback of one register byte
   function automatic logic [7:0] read_byte(input logic [7:0] idx, input logic s,
                                            input logic [4:0] len);
      logic [7:0] v;
      v = CBR_UNHELD;
      case (idx)
         CBR_IDX_SLEW:     v = {CBR_SLEW_RSVD, s};
         CBR_IDX_RSVD:     v = CBR_RSVD_VALUE;
         CBR_IDX_REVMAKER: v = {REVISION_CODE, MAKER_CODE};
         CBR_IDX_CATIDENT: v = {CATEGORY_CODE, PART_IDENT};
         CBR_IDX_LENGTH:   v = {3'b000, len};
         default:          v = CBR_UNHELD;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Writable fields, only defined bit positions take data
   always_comb begin
      next_slew   = slew;
      next_length = length;
      if (wr_en_i && wr_index_i == CBR_IDX_SLEW) begin
         next_slew = wr_data_i[CBR_SLEW_BIT];
      end
      if (wr_en_i && wr_index_i == CBR_IDX_LENGTH) begin
         next_length = wr_data_i[CBR_LEN_MSB:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         slew   <= CBR_SLEW_RESET;
         length <= CBR_LEN_RESET;
      end else begin
         slew   <= next_slew;
         length <= next_length;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block read sequencer: length byte, then register bytes
   always_comb begin
      next_state  = state;
      next_index  = index;
      next_remain = remain;
      next_data   = data;
      case (state)
         CBR_IDLE: begin
            if (rd_start_i) begin
               next_state  = CBR_COUNT;
               next_index  = rd_begin_i;
               next_remain = length;
               next_data   = {3'b000, length};
            end
         end
         CBR_COUNT, CBR_DATA: begin
            if (rd_abort_i) begin
               next_state = CBR_IDLE;
            end else if (rd_start_i) begin
               next_state  = CBR_COUNT;
               next_index  = rd_begin_i;
               next_remain = length;
               next_data   = {3'b000, length};
            end else if (rd_next_i) begin
               if (remain == 5'd0) begin
                  next_state = CBR_IDLE;
               end else begin
                  next_state  = CBR_DATA;
                  next_data   = read_byte(index, slew, length);
                  next_index  = index + 8'd1;
                  next_remain = remain - 5'd1;
               end
            end
         end
         default: next_state = CBR_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state  <= CBR_IDLE;
         index  <= 8'h00;
         remain <= 5'h00;
         data   <= 8'h00;
      end else begin
         state  <= next_state;
         index  <= next_index;
         remain <= next_remain;
         data   <= next_data;
      end
   end

   // Outputs
   assign rd_data_o                = data;
   assign rd_valid_o               = (state != CBR_IDLE);
   assign rd_last_o                = rd_valid_o && (remain == 5'd0);
   assign edge_speed_select_out8_o = slew;
   assign read_length_o            = length;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_slew_write;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_en_i && wr_index_i == CBR_IDX_SLEW |=> edge_speed_select_out8_o == $past(wr_data_i[0]);
   endproperty
   a_slew_write: assert property (p_slew_write) else $error("slew bit not written");

   property p_reset_values;
      @(posedge clock_i)
      !rst_n_i |=> edge_speed_select_out8_o == CBR_SLEW_RESET
         && read_length_o == CBR_LEN_RESET && !rd_valid_o;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset values");

   property p_byte3_rsvd;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_valid_o && rd_next_i && !rd_abort_i && !rd_start_i && !rd_last_o
         && index == CBR_IDX_SLEW
         |=> rd_data_o == {CBR_SLEW_RSVD, $past(edge_speed_select_out8_o)};
   endproperty
   a_byte3_rsvd: assert property (p_byte3_rsvd) else $error("byte 3 readback wrong");

   property p_byte4_ones;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_valid_o && rd_next_i && !rd_abort_i && !rd_start_i && !rd_last_o
         && index == CBR_IDX_RSVD |=> rd_data_o == CBR_RSVD_VALUE;
   endproperty
   a_byte4_ones: assert property (p_byte4_ones) else $error("byte 4 not all ones");

   property p_byte5_fixed;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_valid_o && rd_next_i && !rd_abort_i && !rd_start_i && !rd_last_o
         && index == CBR_IDX_REVMAKER |=> rd_data_o == {REVISION_CODE, MAKER_CODE};
   endproperty
   a_byte5_fixed: assert property (p_byte5_fixed) else $error("byte 5 readback wrong");

   property p_byte6_fixed;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_valid_o && rd_next_i && !rd_abort_i && !rd_start_i && !rd_last_o
         && index == CBR_IDX_CATIDENT |=> rd_data_o == {CATEGORY_CODE, PART_IDENT};
   endproperty
   a_byte6_fixed: assert property (p_byte6_fixed) else $error("byte 6 readback wrong");

   property p_length_write;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_en_i && wr_index_i == CBR_IDX_LENGTH |=> read_length_o == $past(wr_data_i[4:0]);
   endproperty
   a_length_write: assert property (p_length_write) else $error("length not written");

   property p_count_first;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_start_i && !(rd_valid_o && rd_abort_i)
         |=> rd_valid_o && rd_data_o == {3'b000, $past(read_length_o)}
             && index == $past(rd_begin_i);
   endproperty
   a_count_first: assert property (p_count_first) else $error("length byte not first");

   property p_read_length;
      @(posedge clock_i) disable iff (!rst_n_i)
      rd_valid_o && rd_next_i && !rd_abort_i && !rd_start_i
         |=> (rd_valid_o == !$past(rd_last_o));
   endproperty
   a_read_length: assert property (p_read_length) else $error("wrong read length");

   property p_ro_ignored;
      @(posedge clock_i) disable iff (!rst_n_i)
      wr_en_i && wr_index_i != CBR_IDX_SLEW && wr_index_i != CBR_IDX_LENGTH
         |=> $stable(edge_speed_select_out8_o) && $stable(read_length_o);
   endproperty
   a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write took effect");

endmodule // cbr_regs

/* File: tb/cbr_host.sv */
// Host controller model: byte writes and block reads on the register bank
`timescale 1ns/1ps
module cbr_host (
   input  wire logic  clock_i,
   output logic       wr_en_o,
   output logic [7:0] wr_index_o,
   output logic [7:0] wr_data_o,
   output logic       rd_start_o,
   output logic [7:0] rd_begin_o,
   output logic       rd_next_o,
   output logic       rd_abort_o
);
   // Idle levels at time zero
   initial begin
      {wr_en_o, rd_start_o, rd_next_o, rd_abort_o} = 4'h0;
      {wr_index_o, wr_data_o, rd_begin_o} = 24'h00_0000;
   end
   // One byte write, strobe held for one cycle
   task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
      @(negedge clock_i);
      wr_en_o = 1'b1;
      wr_index_o = idx;
      wr_data_o = dat;
      @(negedge clock_i);
      wr_en_o = 1'b0;
      wr_data_o = ~dat; // Released bus shows no stale byte
   endtask
   // Start a block read at beginning index n
   task automatic start(input logic [7:0] n);
      @(negedge clock_i);
      rd_start_o = 1'b1;
      rd_begin_o = n;
      @(negedge clock_i);
      rd_start_o = 1'b0;
      rd_begin_o = ~n;
   endtask
   // One acknowledge or abort pulse
   task automatic step(input logic nxt, input logic abt);
      @(negedge clock_i);
      rd_next_o = nxt;
      rd_abort_o = abt;
      @(negedge clock_i);
      rd_next_o = 1'b0;
      rd_abort_o = 1'b0;
   endtask
endmodule // cbr_host

/* File: tb/test_cbr_regs.sv */
// Self-checking testbench of the upper register bank
`timescale 1ns/1ps
module test_cbr_regs;
   import cbr_pkg::*;
   localparam logic [3:0] REV = 4'hA; // Arbitrary value
   localparam logic [3:0] MAK = 4'h6; // Arbitrary value
   localparam logic [1:0] CAT = 2'h1; // Arbitrary value
   localparam logic [5:0] PID = 6'h2B; // Arbitrary value
   logic       clock_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       wr_en, rd_start, rd_next, rd_abort, rd_valid_o, rd_last_o, slew_o;
   logic [7:0] wr_index, wr_data, rd_begin, rd_data_o;
   logic [4:0] read_length_o;
   logic       slew_exp = 1'b1;
   logic [4:0] len_exp = 5'h08;
   int         error_cnt = 0;
   int         n_compared = 0;
   always #20 clock_i = ~clock_i;
   cbr_host i_cbr_host (.clock_i(clock_i), .wr_en_o(wr_en), .wr_index_o(wr_index),
      .wr_data_o(wr_data), .rd_start_o(rd_start), .rd_begin_o(rd_begin),
      .rd_next_o(rd_next), .rd_abort_o(rd_abort));
   cbr_regs #(.REVISION_CODE(REV), .MAKER_CODE(MAK), .CATEGORY_CODE(CAT), .PART_IDENT(PID))
   i_cbr_regs (.clock_i(clock_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .wr_index_i(wr_index),
      .wr_data_i(wr_data), .rd_start_i(rd_start), .rd_begin_i(rd_begin), .rd_next_i(rd_next),
      .rd_abort_i(rd_abort), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
      .rd_last_o(rd_last_o), .edge_speed_select_out8_o(slew_o), .read_length_o(read_length_o));
   ////////////////////////////////////////////////////////////////////////////////
   // Compare tasks and verdict
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t byte got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t flag got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Expected register byte at an index
   function automatic logic [7:0] exp_byte(input logic [7:0] idx);
      case (idx)
         CBR_IDX_SLEW:     return {CBR_SLEW_RSVD, slew_exp};
         CBR_IDX_RSVD:     return 8'hFF;
         CBR_IDX_REVMAKER: return {REV, MAK};
         CBR_IDX_CATIDENT: return {CAT, PID};
         CBR_IDX_LENGTH:   return {3'h0, len_exp};
         default:          return 8'h00;
      endcase
   endfunction
   // Whole block read from index n, then one more pulse ends it
   task automatic run_read(input logic [7:0] n);
      i_cbr_host.start(n);
      chk_bit(rd_valid_o, 1'b1);
      chk_byte(rd_data_o, {3'h0, len_exp});
      chk_bit(rd_last_o, len_exp == 5'h00);
      for (int i = 0; i < int'(len_exp); i++) begin
         i_cbr_host.step(1'b1, 1'b0);
         chk_byte(rd_data_o, exp_byte(n + 8'(i)));
         chk_bit(rd_last_o, i == int'(len_exp) - 1);
      end
      i_cbr_host.step(1'b1, 1'b0);
      chk_bit(rd_valid_o, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(negedge clock_i);
      rst_n_i = 1'b1;
      chk_bit(slew_o, 1'b1);
      chk_byte({3'h0, read_length_o}, 8'h08);
      i_cbr_host.step(1'b1, 1'b0);
      chk_bit(rd_valid_o, 1'b0);
      $display("Test reset done");
      i_cbr_host.wr(8'h03, 8'h00);
      slew_exp = 1'b0;
      chk_bit(slew_o, 1'b0);
      i_cbr_host.wr(8'h03, 8'hFE);
      chk_bit(slew_o, 1'b0);
      i_cbr_host.wr(8'h07, 8'hE5);
      len_exp = 5'h05;
      chk_byte({3'h0, read_length_o}, 8'h05);
      for (int k = 4; k < 7; k++) i_cbr_host.wr(8'(k), 8'h00);
      run_read(8'h03);
      $display("Test write and read done");
      i_cbr_host.wr(8'h07, 8'hFF);
      chk_byte({3'h0, read_length_o}, 8'h1F);
      i_cbr_host.wr(8'h07, 8'h07);
      i_cbr_host.wr(8'h03, 8'h01);
      {len_exp, slew_exp} = {5'h07, 1'b1};
      run_read(8'hFE);
      i_cbr_host.wr(8'h07, 8'h00);
      len_exp = 5'h00;
      run_read(8'h07);
      $display("Test wrap and zero length done");
      i_cbr_host.wr(8'h07, 8'h02);
      i_cbr_host.start(8'h04);
      i_cbr_host.step(1'b1, 1'b0);
      chk_byte(rd_data_o, 8'hFF);
      i_cbr_host.start(8'h05);
      chk_bit(rd_valid_o, 1'b1);
      chk_byte(rd_data_o, 8'h02);
      chk_bit(rd_last_o, 1'b0);
      i_cbr_host.step(1'b1, 1'b0);
      chk_byte(rd_data_o, exp_byte(8'h05));
      i_cbr_host.step(1'b0, 1'b1);
      chk_bit(rd_valid_o, 1'b0);
      $display("Test restart and abort done");
      i_cbr_host.wr(8'h03, 8'h00);
      chk_bit(slew_o, 1'b0);
      i_cbr_host.start(8'h03);
      rst_n_i = 1'b0;
      repeat (2) @(negedge clock_i);
      rst_n_i = 1'b1;
      {len_exp, slew_exp} = {5'h08, 1'b1};
      chk_bit(rd_valid_o, 1'b0);
      chk_bit(slew_o, 1'b1);
      chk_byte({3'h0, read_length_o}, 8'h08);
      run_read(8'h06);
      $display("Test reset in mid-run done");
      print_verdict();
   end
   // Watchdog
   initial begin
      #400000;
      error_cnt++;
      print_verdict();
   end
endmodule // test_cbr_regs
